// [hdl/cred_pkg.sv]
`default_nettype none
package cred_pkg;
    // Data widths of the console paths.
    localparam int P_W = 15;
    localparam int WORD_W = 24;
    localparam int EXT_W = 48;
    localparam int CIR_W = 3;
    localparam int ADDR_W = 18;
    localparam int PF_W = 7;
    localparam int DIG_W = 3;
    localparam int MODE_W = 4;
    localparam int DSEL_W = 4;
    localparam int RATE_W = 8;
    localparam int CNT_W = 32;
    localparam int APB_AW = 8;
    localparam int APB_DW = 32;

    // Register byte offsets on the APB port.
    localparam logic [APB_AW-1:0] OFS_CTRL = 8'h00;
    localparam logic [APB_AW-1:0] OFS_BKPT = 8'h04;
    localparam logic [APB_AW-1:0] OFS_KEY = 8'h08;
    localparam logic [APB_AW-1:0] OFS_KBD = 8'h0C;
    localparam logic [APB_AW-1:0] OFS_DISP = 8'h10;
    localparam logic [APB_AW-1:0] OFS_STAT = 8'h14;

    // Field positions of the control register.
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_DSEL_LSB = 4;
    localparam int CTRL_AUTO_BIT = 8;
    localparam int CTRL_RF_BIT = 9;
    localparam int CTRL_RATE_LSB = 16;

    // Field positions of the key register; a write is one press.
    localparam int KEY_DIG_LSB = 0;
    localparam int KEY_DIG_BIT = 3;
    localparam int KEY_CLR_BIT = 4;
    localparam int KEY_XFER_BIT = 5;

    // Bit positions of the status register.
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_FIRST_BIT = 1;
    localparam int STAT_LOCK_BIT = 2;
    localparam int STAT_HALT_BIT = 3;

    // Auto-step pacing: one rate unit lasts this long.
    localparam int STEP_UNIT_NS = 1000000;
    localparam int CLK_PERIOD_NS = 20;
    localparam int STEP_UNIT_CYC = (STEP_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Keyboard mode switch positions.
    typedef enum logic [MODE_W-1:0] {
        KM_OFF = 4'h0, KM_P = 4'h1, KM_IDX1 = 4'h2, KM_IDX2 = 4'h3, KM_IDX3 = 4'h4,
        KM_ACC = 4'h5, KM_AUX = 4'h6, KM_SWEEP = 4'h7, KM_ENTER = 4'h8,
        KM_BRD = 4'h9, KM_BWR = 4'hA, KM_PFSW = 4'hB, KM_PFEN = 4'hC
    } cred_kmode_t;

    // Display selection switch positions.
    typedef enum logic [DSEL_W-1:0] {
        DS_P = 4'h0, DS_IDX1 = 4'h1, DS_IDX2 = 4'h2, DS_IDX3 = 4'h3, DS_LJA = 4'h4,
        DS_CIR = 4'h5, DS_ACC = 4'h6, DS_AUX = 4'h7, DS_EXTU = 4'h8, DS_EXTL = 4'h9
    } cred_dsel_t;

    // Destination of a keyboard transfer into a processor register.
    typedef enum logic [2:0] {
        DST_P = 3'h0, DST_IDX1 = 3'h1, DST_IDX2 = 3'h2, DST_IDX3 = 3'h3,
        DST_ACC = 3'h4, DST_AUX = 3'h5
    } cred_dest_t;

    // Target array of a memory request.
    typedef enum logic [1:0] {
        TGT_STORAGE = 2'h0, TGT_REGFILE = 2'h1, TGT_PAGEFILE = 2'h2
    } cred_target_t;

    // Sequencer states.
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00, ST_MEM = 2'b01
    } cred_state_t;

    // Processor state seen by the console.
    typedef struct packed {
        logic halted;
        logic bp_stop;
        logic cycle_lock;
        logic [P_W-1:0] p;
        logic [P_W-1:0] index_register_one;
        logic [P_W-1:0] index_register_two;
        logic [P_W-1:0] index_register_three;
        logic [P_W-1:0] last_jump_address;
        logic [CIR_W-1:0] channel_index_register;
        logic [WORD_W-1:0] acc;
        logic [WORD_W-1:0] aux;
        logic [EXT_W-1:0] ext;
    } cred_cpu_view_t;

    typedef struct packed {
        logic valid;
        logic write;
        cred_target_t target;
        logic [ADDR_W-1:0] addr;
        logic [WORD_W-1:0] wdata;
    } cred_mem_req_t;

    typedef struct packed {
        logic ack;
        logic [WORD_W-1:0] rdata;
    } cred_mem_rsp_t;

    typedef struct packed {
        logic valid;
        cred_dest_t dest;
        logic [WORD_W-1:0] data;
    } cred_reg_wr_t;

    // Whole state of the console block.
    typedef struct packed {
        cred_kmode_t mode;
        cred_dsel_t dsel;
        logic auto_step;
        logic bkpt_rf;
        logic [RATE_W-1:0] rate;
        logic [ADDR_W-1:0] bkpt;
        logic [WORD_W-1:0] kbd;
        logic first;
        cred_state_t fsm;
        logic upd_p;
        logic [P_W-1:0] next_p;
        logic [CNT_W-1:0] step_cnt;
        logic [RATE_W-1:0] rate_cnt;
        logic pready;
        logic [APB_DW-1:0] prdata;
        logic pslverr;
        logic [WORD_W-1:0] disp;
        cred_mem_req_t mreq;
        cred_reg_wr_t rwr;
    } cred_state_s_t;
endpackage
`default_nettype wire

// [hdl/cred_console.sv]
// Operation
// - Keyboard input ignored on breakpoint halt or storage-cycle-step operand/indirect lock.
// - Display selection only picks the displayed register, never alters registers.
// - P selection shows P both while running and when halted.
// - Index selection shows the chosen 15-bit index register when halted.
// - Last-jump selection shows last jump base address when halted.
// - Channel index shown in lowest octal digit of display when halted.
// - Accumulator or auxiliary selection shows that 24-bit register when halted.
// - Upper or lower half of 48-bit extended register shown when halted.
// - Entry modes pick P, an index, accumulator or auxiliary as destination.
// - Sweep reads storage at P into keyboard register; advance except first.
// - Enter writes keyboard register to storage at P when halted, then advances.
// - Auto-step repeats sweep and enter transfers at the step rate.
// - Breakpoint write stores keyboard register at breakpoint address on transfer.
// - Page-file sweep loads page index at low 7 bits of P.
// - Page-file enter writes page index at low 7 bits of P, then advances.
// - Keyboard mode off disables every key and transfer.
// - Keyboard clear zeroes the whole keyboard register.
// - Eight numeric keys enter octal digits zero to seven.
// - Transfer copies keyboard register into selected register or memory location.
`default_nettype none
module cred_console #(
    parameter int STEP_UNIT_CYC = cred_pkg::STEP_UNIT_CYC
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic resetn,
    // APB slave.
    input wire logic [cred_pkg::APB_AW-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [cred_pkg::APB_DW-1:0] pwdata,
    output logic [cred_pkg::APB_DW-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Processor view and register load.
    input wire cred_pkg::cred_cpu_view_t cpu,
    output cred_pkg::cred_reg_wr_t reg_wr,
    // Memory access to storage, register file and page index file.
    output cred_pkg::cred_mem_req_t mem_req,
    input wire cred_pkg::cred_mem_rsp_t mem_rsp,
    // Console display.
    output logic [cred_pkg::WORD_W-1:0] display
);

    // Picks the displayed word from the processor view.
    function automatic logic [cred_pkg::WORD_W-1:0] disp_word(
        input cred_pkg::cred_cpu_view_t c,
        input cred_pkg::cred_dsel_t s
    );
        logic [cred_pkg::WORD_W-1:0] w;
        w = '0;
        if (!c.halted) begin
            if (s == cred_pkg::DS_P) begin
                w = cred_pkg::WORD_W'(c.p);
            end
        end else begin
            case (s)
                cred_pkg::DS_IDX1: w = cred_pkg::WORD_W'(c.index_register_one);
                cred_pkg::DS_IDX2: w = cred_pkg::WORD_W'(c.index_register_two);
                cred_pkg::DS_IDX3: w = cred_pkg::WORD_W'(c.index_register_three);
                cred_pkg::DS_LJA: w = cred_pkg::WORD_W'(c.last_jump_address);
                cred_pkg::DS_CIR: w = cred_pkg::WORD_W'(c.channel_index_register);
                cred_pkg::DS_ACC: w = c.acc;
                cred_pkg::DS_AUX: w = c.aux;
                cred_pkg::DS_EXTU: w = c.ext[cred_pkg::EXT_W-1:cred_pkg::WORD_W];
                cred_pkg::DS_EXTL: w = c.ext[cred_pkg::WORD_W-1:0];
                default: w = cred_pkg::WORD_W'(c.p);
            endcase
        end
        return w;
    endfunction

    // Next sweep address: P itself on the first transfer, P plus one after.
    function automatic logic [cred_pkg::P_W-1:0] sweep_addr(
        input logic [cred_pkg::P_W-1:0] p,
        input logic first
    );
        return first ? p : cred_pkg::P_W'(p + 1'b1);
    endfunction

    cred_pkg::cred_state_s_t st_q;
    cred_pkg::cred_state_s_t st_d;

    // Bus phase decode and press decode.
    logic apb_setup;
    logic apb_wr;
    logic key_wr;
    logic ctrl_wr;
    logic kb_lock;
    logic kb_en;
    logic unit_tick;
    logic step_tick;
    logic paced_mode;
    logic xfer_fire;
    logic mem_done;
    logic [cred_pkg::P_W-1:0] sw_p;

    // A press is a single APB write, so it is acted on once.
    assign apb_setup = psel && !penable;
    assign apb_wr = psel && penable && st_q.pready && pwrite;
    assign key_wr = apb_wr && (paddr == cred_pkg::OFS_KEY);
    assign ctrl_wr = apb_wr && (paddr == cred_pkg::OFS_CTRL);
    assign kb_lock = cpu.bp_stop || cpu.cycle_lock;
    assign kb_en = (st_q.mode != cred_pkg::KM_OFF) && !kb_lock;
    assign mem_done = (st_q.fsm == cred_pkg::ST_MEM) && mem_rsp.ack;
    assign sw_p = sweep_addr(cpu.p, st_q.first);

    // Step-rate timer: the interval is rate plus one units.
    assign unit_tick = st_q.step_cnt == cred_pkg::CNT_W'(STEP_UNIT_CYC - 1);
    assign step_tick = unit_tick && (st_q.rate_cnt == st_q.rate);
    assign paced_mode = (st_q.mode == cred_pkg::KM_SWEEP) || (st_q.mode == cred_pkg::KM_ENTER)
        || (st_q.mode == cred_pkg::KM_PFSW) || (st_q.mode == cred_pkg::KM_PFEN);

    // Transfer source: manual press, auto-step tick, or breakpoint-read pacing.
    always_comb begin
        xfer_fire = 1'b0;
        if (kb_en && st_q.fsm == cred_pkg::ST_IDLE) begin
            if (st_q.mode == cred_pkg::KM_BRD) begin
                xfer_fire = step_tick;
            end else if (paced_mode && st_q.auto_step) begin
                xfer_fire = step_tick;
            end else begin
                xfer_fire = key_wr && pwdata[cred_pkg::KEY_XFER_BIT];
            end
        end
    end

    // Next state of the whole block.
    always_comb begin
        st_d = st_q;
        st_d.rwr.valid = 1'b0;
        st_d.pready = apb_setup;
        st_d.disp = disp_word(cpu, st_q.dsel);

        // Step timer runs free between ticks.
        st_d.step_cnt = unit_tick ? '0 : st_q.step_cnt + 1'b1;
        if (unit_tick) begin
            st_d.rate_cnt = step_tick ? '0 : st_q.rate_cnt + 1'b1;
        end

        // Register reads are prepared in the setup cycle.
        if (apb_setup) begin
            st_d.pslverr = 1'b0;
            st_d.prdata = '0;
            case (paddr)
                cred_pkg::OFS_CTRL: begin
                    st_d.prdata[cred_pkg::CTRL_MODE_LSB +: cred_pkg::MODE_W] = st_q.mode;
                    st_d.prdata[cred_pkg::CTRL_DSEL_LSB +: cred_pkg::DSEL_W] = st_q.dsel;
                    st_d.prdata[cred_pkg::CTRL_AUTO_BIT] = st_q.auto_step;
                    st_d.prdata[cred_pkg::CTRL_RF_BIT] = st_q.bkpt_rf;
                    st_d.prdata[cred_pkg::CTRL_RATE_LSB +: cred_pkg::RATE_W] = st_q.rate;
                end
                cred_pkg::OFS_BKPT: st_d.prdata[cred_pkg::ADDR_W-1:0] = st_q.bkpt;
                cred_pkg::OFS_KEY: st_d.prdata = '0;
                cred_pkg::OFS_KBD: st_d.prdata[cred_pkg::WORD_W-1:0] = st_q.kbd;
                cred_pkg::OFS_DISP: st_d.prdata[cred_pkg::WORD_W-1:0] = st_q.disp;
                cred_pkg::OFS_STAT: begin
                    st_d.prdata[cred_pkg::STAT_BUSY_BIT] = st_q.fsm != cred_pkg::ST_IDLE;
                    st_d.prdata[cred_pkg::STAT_FIRST_BIT] = st_q.first;
                    st_d.prdata[cred_pkg::STAT_LOCK_BIT] = kb_lock;
                    st_d.prdata[cred_pkg::STAT_HALT_BIT] = cpu.halted;
                end
                default: st_d.pslverr = 1'b1;
            endcase
        end

        // Switch settings; a control register write restarts the first-transfer state unless a sweep or page-file sweep transfer fires in that cycle.
        if (ctrl_wr) begin
            st_d.mode = cred_pkg::cred_kmode_t'(pwdata[cred_pkg::CTRL_MODE_LSB +: cred_pkg::MODE_W]);
            st_d.dsel = cred_pkg::cred_dsel_t'(pwdata[cred_pkg::CTRL_DSEL_LSB +: cred_pkg::DSEL_W]);
            st_d.auto_step = pwdata[cred_pkg::CTRL_AUTO_BIT];
            st_d.bkpt_rf = pwdata[cred_pkg::CTRL_RF_BIT];
            st_d.rate = pwdata[cred_pkg::CTRL_RATE_LSB +: cred_pkg::RATE_W];
            st_d.first = 1'b1;
        end
        if (apb_wr && paddr == cred_pkg::OFS_BKPT) begin
            st_d.bkpt = pwdata[cred_pkg::ADDR_W-1:0];
        end

        // Clear first, then a digit, within the same press.
        if (key_wr && kb_en) begin
            if (pwdata[cred_pkg::KEY_CLR_BIT]) begin
                st_d.kbd = '0;
            end
            if (pwdata[cred_pkg::KEY_DIG_BIT]) begin
                st_d.kbd = {st_d.kbd[cred_pkg::WORD_W-cred_pkg::DIG_W-1:0],
                    pwdata[cred_pkg::KEY_DIG_LSB +: cred_pkg::DIG_W]};
            end
        end

        // Transfer sequencer.
        case (st_q.fsm)
            cred_pkg::ST_IDLE: begin
                if (xfer_fire) begin
                    st_d.upd_p = 1'b0;
                    st_d.mreq.wdata = st_q.kbd;
                    case (st_q.mode)
                        cred_pkg::KM_P, cred_pkg::KM_IDX1, cred_pkg::KM_IDX2,
                        cred_pkg::KM_IDX3, cred_pkg::KM_ACC, cred_pkg::KM_AUX: begin
                            st_d.rwr.valid = 1'b1;
                            st_d.rwr.dest = cred_pkg::cred_dest_t'(3'(st_q.mode - 1'b1));
                            st_d.rwr.data = st_q.kbd;
                        end
                        cred_pkg::KM_SWEEP, cred_pkg::KM_PFSW: begin
                            st_d.mreq.valid = 1'b1;
                            st_d.mreq.write = 1'b0;
                            if (st_q.mode == cred_pkg::KM_SWEEP) begin
                                st_d.mreq.target = cred_pkg::TGT_STORAGE;
                                st_d.mreq.addr = cred_pkg::ADDR_W'(sw_p);
                            end else begin
                                st_d.mreq.target = cred_pkg::TGT_PAGEFILE;
                                st_d.mreq.addr = cred_pkg::ADDR_W'(sw_p[cred_pkg::PF_W-1:0]);
                            end
                            st_d.upd_p = !st_q.first;
                            st_d.next_p = sw_p;
                            st_d.first = 1'b0;
                            st_d.fsm = cred_pkg::ST_MEM;
                        end
                        cred_pkg::KM_ENTER: begin
                            if (cpu.halted) begin
                                st_d.mreq.valid = 1'b1;
                                st_d.mreq.write = 1'b1;
                                st_d.mreq.target = cred_pkg::TGT_STORAGE;
                                st_d.mreq.addr = cred_pkg::ADDR_W'(cpu.p);
                                st_d.upd_p = 1'b1;
                                st_d.next_p = cred_pkg::P_W'(cpu.p + 1'b1);
                                st_d.fsm = cred_pkg::ST_MEM;
                            end
                        end
                        cred_pkg::KM_PFEN: begin
                            st_d.mreq.valid = 1'b1;
                            st_d.mreq.write = 1'b1;
                            st_d.mreq.target = cred_pkg::TGT_PAGEFILE;
                            st_d.mreq.addr = cred_pkg::ADDR_W'(cpu.p[cred_pkg::PF_W-1:0]);
                            st_d.upd_p = 1'b1;
                            st_d.next_p = cred_pkg::P_W'(cpu.p + 1'b1);
                            st_d.fsm = cred_pkg::ST_MEM;
                        end
                        cred_pkg::KM_BRD, cred_pkg::KM_BWR: begin
                            st_d.mreq.valid = 1'b1;
                            st_d.mreq.write = st_q.mode == cred_pkg::KM_BWR;
                            st_d.mreq.target = st_q.bkpt_rf ? cred_pkg::TGT_REGFILE
                                : cred_pkg::TGT_STORAGE;
                            st_d.mreq.addr = st_q.bkpt;
                            st_d.fsm = cred_pkg::ST_MEM;
                        end
                        default: st_d.fsm = cred_pkg::ST_IDLE;
                    endcase
                end
            end
            cred_pkg::ST_MEM: begin
                if (mem_rsp.ack) begin
                    st_d.mreq.valid = 1'b0;
                    if (!st_q.mreq.write) begin
                        st_d.kbd = mem_rsp.rdata;
                    end
                    if (st_q.upd_p) begin
                        st_d.rwr.valid = 1'b1;
                        st_d.rwr.dest = cred_pkg::DST_P;
                        st_d.rwr.data = cred_pkg::WORD_W'(st_q.next_p);
                    end
                    st_d.fsm = cred_pkg::ST_IDLE;
                end
            end
            default: st_d.fsm = cred_pkg::ST_IDLE;
        endcase
    end

    // State register with synchronous reset.
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            st_q <= '0;
            st_q.first <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs come straight from the state register.
    assign prdata = st_q.prdata;
    assign pready = st_q.pready;
    assign pslverr = st_q.pslverr;
    assign reg_wr = st_q.rwr;
    assign mem_req = st_q.mreq;
    assign display = st_q.disp;

    // Checks of the console behaviour.
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    AST_LOCK_IGNORES: assert property (key_wr && kb_lock |=> $stable(st_q.kbd))
        else $error("Keyboard changed while locked.");
    AST_OFF_IGNORES: assert property (key_wr && st_q.mode == cred_pkg::KM_OFF
        && st_q.fsm == cred_pkg::ST_IDLE |=> $stable(st_q.kbd) && !st_q.mreq.valid
        && !st_q.rwr.valid)
        else $error("Key acted on with keyboard off.");
    AST_CLEAR_ZERO: assert property (key_wr && kb_en && pwdata[cred_pkg::KEY_CLR_BIT]
        && !pwdata[cred_pkg::KEY_DIG_BIT] && st_q.fsm == cred_pkg::ST_IDLE
        |=> st_q.kbd == '0)
        else $error("Keyboard clear did not zero register.");
    AST_DIGIT_SHIFT: assert property (key_wr && kb_en && !pwdata[cred_pkg::KEY_CLR_BIT]
        && pwdata[cred_pkg::KEY_DIG_BIT] && st_q.fsm == cred_pkg::ST_IDLE
        |=> st_q.kbd == {$past(st_q.kbd[cred_pkg::WORD_W-cred_pkg::DIG_W-1:0]),
        $past(pwdata[cred_pkg::KEY_DIG_LSB +: cred_pkg::DIG_W])})
        else $error("Digit entry did not shift in digit.");
    AST_REG_WR_CAUSE: assert property (st_q.rwr.valid |-> $past(xfer_fire) || $past(mem_done))
        else $error("Register load without a transfer.");
    AST_DISP_P_HALT: assert property (cpu.halted && st_q.dsel == cred_pkg::DS_P
        |=> st_q.disp == cred_pkg::WORD_W'($past(cpu.p)))
        else $error("P not displayed while halted.");
    AST_DISP_CIR: assert property (cpu.halted && st_q.dsel == cred_pkg::DS_CIR
        |=> st_q.disp == cred_pkg::WORD_W'($past(cpu.channel_index_register)))
        else $error("Channel index not in low digit.");
    AST_SWEEP_FIRST: assert property (xfer_fire && st_q.mode == cred_pkg::KM_SWEEP && st_q.first
        |=> st_q.mreq.valid && st_q.mreq.addr == cred_pkg::ADDR_W'($past(cpu.p))
        ##0 !st_q.upd_p)
        else $error("First sweep did not read at P.");
    AST_ENTER_WRITE: assert property (xfer_fire && st_q.mode == cred_pkg::KM_ENTER && cpu.halted
        |=> st_q.mreq.valid && st_q.mreq.write && st_q.mreq.wdata == $past(st_q.kbd)
        && st_q.next_p == cred_pkg::P_W'($past(cpu.p) + 1'b1))
        else $error("Enter did not write keyboard word at P.");
    AST_ENTER_RUNNING: assert property (xfer_fire && st_q.mode == cred_pkg::KM_ENTER
        && !cpu.halted |=> !st_q.mreq.valid)
        else $error("Enter acted while running.");
    AST_XFER_REG: assert property (xfer_fire && st_q.mode == cred_pkg::KM_ACC
        |=> st_q.rwr.valid && st_q.rwr.dest == cred_pkg::DST_ACC
        && st_q.rwr.data == $past(st_q.kbd))
        else $error("Transfer into accumulator wrong.");

    COV_SWEEP_STEP: cover property (xfer_fire && st_q.mode == cred_pkg::KM_SWEEP && !st_q.first);
    COV_ENTER_DONE: cover property (mem_done && st_q.upd_p && st_q.mreq.write);
    COV_AUTO_STEP: cover property (step_tick && st_q.auto_step && xfer_fire);

endmodule // cred_console
`default_nettype wire

// [tb/cred_mem_model.sv]
`default_nettype none
module cred_mem_model #(
    parameter int DLY = 2
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic resetn,
    // Memory port.
    input wire cred_pkg::cred_mem_req_t mem_req,
    output cred_pkg::cred_mem_rsp_t mem_rsp,
    // Last access seen.
    output logic [17:0] last_addr,
    output logic [23:0] last_wdata
);
    int cnt;
    // Acks after DLY waits; read data churns outside the ack cycle.
    always @(posedge clk_sys) begin
        if (!resetn) begin
            cnt <= 0;
            mem_rsp <= '0;
        end else if (mem_req.valid && !mem_rsp.ack && cnt == DLY) begin
            cnt <= 0;
            mem_rsp <= {1'b1, 6'h15, mem_req.addr};
            last_addr <= mem_req.addr;
            last_wdata <= mem_req.wdata;
        end else begin
            mem_rsp <= {1'b0, ~mem_rsp.rdata};
            if (mem_req.valid && !mem_rsp.ack) cnt <= cnt + 1;
        end
    end
endmodule // cred_mem_model
`default_nettype wire

// [tb/tb_top.sv]
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    cred_pkg::cred_cpu_view_t cpu = '0;
    cred_pkg::cred_reg_wr_t reg_wr, rw_q = '0;
    cred_pkg::cred_mem_req_t mem_req;
    cred_pkg::cred_mem_rsp_t mem_rsp;
    logic [23:0] display, wdat;
    logic [17:0] maddr;
    int errors = 0, compares = 0;
    cred_console #(.STEP_UNIT_CYC(4)) cred_console_inst (.clk_sys(clk_sys), .resetn(resetn),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpu(cpu), .reg_wr(reg_wr),
        .mem_req(mem_req), .mem_rsp(mem_rsp), .display(display));
    cred_mem_model cred_mem_model_inst (.clk_sys(clk_sys), .resetn(resetn), .mem_req(mem_req),
        .mem_rsp(mem_rsp), .last_addr(maddr), .last_wdata(wdat));
    // Free-running system clock.
    always #10 clk_sys = ~clk_sys;
    // Keeps the last register load.
    always @(posedge clk_sys) if (reg_wr.valid === 1'b1) rw_q <= reg_wr;
    task print_verdict;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input string n, input logic [47:0] e, input logic [47:0] g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin @(negedge clk_sys); n++; end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        @(posedge clk_sys);
        {psel, penable} <= 2'b00;
        if (n >= 50) begin errors++; print_verdict; end
    endtask
    task key(input logic [5:0] v); apb(1'b1, cred_pkg::OFS_KEY, {26'h0, v}); endtask
    task ctrl(input logic [3:0] m, input logic [3:0] s); apb(1'b1, 8'h00, {24'h0, s, m}); endtask
    task kbd_is(input logic [23:0] e); apb(1'b0, cred_pkg::OFS_KBD, 0); chk("kbd", e, rd[23:0]);
    endtask
    task disp_is(input logic [3:0] s, input logic [23:0] e);
        ctrl(cred_pkg::KM_OFF, s);
        repeat (3) @(posedge clk_sys);
        chk("display", e, display);
    endtask
    task wait_idle;
        int n;
        n = 0;
        do begin apb(1'b0, cred_pkg::OFS_STAT, 0); n++; end while (rd[0] !== 1'b0 && n < 20);
        if (n >= 20) begin errors++; print_verdict; end
    endtask
    // Main sequence: reset, then keyboard, display and storage steps.
    initial begin
        {cpu.halted, cpu.p, cpu.channel_index_register} <= {1'b1, 15'h0123, 3'h5};
        cpu.ext <= 48'hABCDEF123456;
        repeat (10) @(posedge clk_sys);
        resetn <= 1'b1;
        ctrl(cred_pkg::KM_OFF, cred_pkg::DS_P);
        key(6'h0D);
        kbd_is(24'h0);
        ctrl(cred_pkg::KM_ACC, cred_pkg::DS_P);
        key(6'h10);
        for (int d = 0; d < 8; d++) key({3'b001, d[2:0]});
        kbd_is(24'h053977);
        key(6'h20);
        repeat (3) @(posedge clk_sys);
        chk("dest", cred_pkg::DST_ACC, rw_q.dest);
        chk("load", 24'h053977, rw_q.data);
        for (int i = 0; i < 2; i++) begin
            {cpu.bp_stop, cpu.cycle_lock} <= (i == 0) ? 2'b10 : 2'b01;
            key(6'h11);
            kbd_is(24'h053977);
        end
        {cpu.bp_stop, cpu.cycle_lock} <= 2'b00;
        key(6'h10);
        kbd_is(24'h0);
        $display("keyboard test done");
        disp_is(cred_pkg::DS_P, 24'h000123);
        disp_is(cred_pkg::DS_CIR, 24'h000005);
        disp_is(cred_pkg::DS_EXTU, 24'hABCDEF);
        disp_is(cred_pkg::DS_EXTL, 24'h123456);
        $display("display test done");
        ctrl(cred_pkg::KM_SWEEP, cred_pkg::DS_P);
        key(6'h20);
        wait_idle;
        chk("sweep addr", 18'h00123, maddr);
        kbd_is(24'h540123);
        key(6'h20);
        wait_idle;
        chk("sweep addr", 18'h00124, maddr);
        chk("sweep p", 15'h0124, rw_q.data[14:0]);
        ctrl(cred_pkg::KM_ENTER, cred_pkg::DS_P);
        key(6'h1E);
        key(6'h20);
        wait_idle;
        chk("enter addr", 18'h00123, maddr);
        chk("enter data", 24'h000006, wdat);
        chk("enter p", 15'h0124, rw_q.data[14:0]);
        ctrl(cred_pkg::KM_PFEN, cred_pkg::DS_P);
        key(6'h20);
        wait_idle;
        chk("pf addr", 18'h00023, maddr);
        apb(1'b1, cred_pkg::OFS_BKPT, 32'h00000155);
        ctrl(cred_pkg::KM_BWR, cred_pkg::DS_P);
        key(6'h20);
        wait_idle;
        chk("bkpt addr", 18'h00155, maddr);
        ctrl(cred_pkg::KM_BRD, cred_pkg::DS_P);
        repeat (20) @(posedge clk_sys);
        kbd_is(24'h540155);
        ctrl(cred_pkg::KM_OFF, cred_pkg::DS_P);
        wait_idle;
        $display("storage test done");
        apb(1'b0, 8'h20, 0);
        chk("pslverr", 1'b1, err);
        $display("bus test done");
        print_verdict;
    end
endmodule // tb_top
`default_nettype wire
